// >>> sci_pkg.sv
// Constants shared by the serial character interface
package sci_pkg;

    // System clock
    localparam int unsigned CLK_HZ = 50_000_000;

    // Selectable bit rates, fastest first
    localparam int unsigned BAUD_1200 = 1200;
    localparam int unsigned BAUD_600 = 600;
    localparam int unsigned BAUD_300 = 300;
    localparam int unsigned BAUD_150 = 150;
    localparam int unsigned BAUD_110 = 110;

    // Rate selector positions
    localparam logic [2:0] RATE_POS_1200 = 3'h0;
    localparam logic [2:0] RATE_POS_600 = 3'h1;
    localparam logic [2:0] RATE_POS_300 = 3'h2;
    localparam logic [2:0] RATE_POS_150 = 3'h3;

    // Output hold-off after a control character
    localparam int unsigned DELAY_MS = 200;
    localparam int unsigned DELAY_CYC = (CLK_HZ / 1000) * DELAY_MS;

    // Oscillator runs at twice the bit rate: cycles per half bit
    localparam int unsigned HALF_1200 = CLK_HZ / (2 * BAUD_1200);
    localparam int unsigned HALF_600 = CLK_HZ / (2 * BAUD_600);
    localparam int unsigned HALF_300 = CLK_HZ / (2 * BAUD_300);
    localparam int unsigned HALF_150 = CLK_HZ / (2 * BAUD_150);
    localparam int unsigned HALF_110 = CLK_HZ / (2 * BAUD_110);
    localparam int unsigned DIV_W = 24;

    // Bit counter end states and stop-bit sample position
    localparam logic [3:0] LAST_10BIT = 4'h9;
    localparam logic [3:0] LAST_11BIT = 4'ha;
    localparam logic [3:0] RX_STOP_IDX = 4'h9;

    // Select code mapping for switch position zero
    localparam logic [3:0] SEL_POS_ZERO = 4'h0;
    localparam logic [3:0] SEL_ZERO_CODE = 4'hf;

    // Control characters that start the output delay
    localparam logic [7:0] CTRL_CHAR [6] = '{8'h07, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d};

    // Synchroniser layout and reset value (line idles at mark)
    localparam int unsigned SYNC_W = 12;
    localparam logic [11:0] SYNC_RST = 12'h800;

    // Receive buffer depth
    localparam logic [1:0] BUF_FULL = 2'h2;

    typedef enum logic [2:0] {SCI_IDLE, SCI_TX, SCI_RX_ARM, SCI_RX_RUN, SCI_HOLD} sci_state_t;

endpackage

// >>> sci_term_model.sv
// Terminal model: decodes the serial output and sends characters on request
`timescale 1ns/100ps
module sci_term_model (
    // Clock
    input wire logic clk,
    // Lines from the interface
    input wire logic ser_out,
    input wire logic cts,
    // Control from the bench
    input wire logic [31:0] bit_cyc,
    input wire logic two_stop,
    input wire logic go,
    input wire logic [7:0] tx_byte,
    // Line to the interface and decoded output
    output logic ser_in,
    output logic [7:0] got,
    output int got_n
);
    // Line idles at mark so a stray low is never taken for a start bit
    initial begin
        ser_in = 1'b1;
        got = 8'h00;
        got_n = 0;
    end
    // Receiver samples mid bit, first data bit into bit 0
    always begin
        @(negedge ser_out);
        repeat (bit_cyc / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (bit_cyc) @(posedge clk);
            got[i] = ser_out;
        end
        repeat (bit_cyc) @(posedge clk);
        got_n++;
    end
    // Sender holds off until send-clear, then start bit, data, stop bits
    always @(posedge go) begin
        wait (cts === 1'b1);
        repeat (2) @(posedge clk);
        ser_in <= 1'b0;
        repeat (bit_cyc) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            ser_in <= tx_byte[i];
            repeat (bit_cyc) @(posedge clk);
        end
        ser_in <= 1'b1;
        repeat (two_stop ? 2 * bit_cyc : bit_cyc) @(posedge clk);
    end
endmodule

// >>> sci_top.sv
// Serial character interface: parallel port to framed serial terminal link
//
// Operation
// - Strap selects ten or eleven bit framing
// - Ten-bit framing gives one fewer clock pulse
// - Standard mode: drop send-clear at start bit
// - Alternate mode: hold send-clear until first stop
// - Respond only on matching code; zero means fifteen
// - Strap picks internal delay or external busy
// - Fastest rate setting gives 1200 Hz clock
// - Start bit enables clock for 10/11 counts
// - Counter from zero; overflow past end terminates
// - Shift stage by stage; last stage drives output
// - Control characters start 200 ms hold-off pulse
// - Second received stop bit is ignored
// - Output mode at reset and frame end
// - Oscillator at twice rate, halved by flip-flop
`timescale 1ns/100ps
module sci_top
    import sci_pkg::*;
#(
    parameter int unsigned HALF_CYC_1200 = HALF_1200,
    parameter int unsigned HALF_CYC_600 = HALF_600,
    parameter int unsigned HALF_CYC_300 = HALF_300,
    parameter int unsigned HALF_CYC_150 = HALF_150,
    parameter int unsigned HALF_CYC_110 = HALF_110,
    parameter int unsigned DELAY_CYCLES = DELAY_CYC
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic NRST,
    // Calculator request port
    input wire logic CMD_VALID,
    output logic CMD_READY,
    input wire logic [3:0] CMD_SELECT,
    input wire logic CMD_WRITE,
    input wire logic [7:0] CMD_DATA,
    output logic BUSY,
    // Received characters to the calculator
    output logic RX_VALID,
    input wire logic RX_READY,
    output logic [7:0] RX_DATA,
    // Straps and switches
    input wire logic FRAME_LENGTH_STRAP,
    input wire logic CTS_HOLDOFF_STRAP,
    input wire logic DELAY_SOURCE_STRAP,
    input wire logic [3:0] SELECT_CODE_SWITCH,
    input wire logic [2:0] RATE_SELECTOR,
    // Terminal link
    input wire logic SER_DATA_IN,
    output logic SER_DATA_OUT,
    output logic CLEAR_TO_SEND,
    input wire logic PERIPH_BUSY_IN
);

    logic [SYNC_W-1:0] sync1_q, sync2_q;
    logic s_din, s_pbusy, s_frame11, s_alt, s_ext;
    logic [3:0] s_switch;
    logic [2:0] s_rate;
    sci_state_t state_q;
    logic busy_q, tog_q, out_q, push_q, wp_q, rp_q;
    logic [DIV_W-1:0] div_q, half_m1, dly_q;
    logic [3:0] cnt_q, last;
    logic [9:0] sr_q;
    logic [1:0] buf_cnt_q;
    logic [7:0] buf_mem [2];
    logic running, tick2x, shift_edge, term, shift_en, accept, sel_match, is_ctrl, tx_phase;
    logic [3:0] eff_code;

    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7 - i];
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Serial data in, peripheral busy in and every strap and switch pass two flip-flops
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            sync1_q <= SYNC_RST;
            sync2_q <= SYNC_RST;
        end else begin
            sync1_q <= {SER_DATA_IN, PERIPH_BUSY_IN, FRAME_LENGTH_STRAP, CTS_HOLDOFF_STRAP,
                        DELAY_SOURCE_STRAP, SELECT_CODE_SWITCH, RATE_SELECTOR};
            sync2_q <= sync1_q;
        end
    end

    assign s_din = sync2_q[11];
    assign s_pbusy = sync2_q[10];
    assign s_frame11 = sync2_q[9];
    assign s_alt = sync2_q[8];
    assign s_ext = sync2_q[7];
    assign s_switch = sync2_q[6:3];
    assign s_rate = sync2_q[2:0];

    ////////////////////////////////////////////////////////////////////////////
    // Request decode; a read waits for room in the receive buffer
    assign eff_code = (s_switch == SEL_POS_ZERO) ? SEL_ZERO_CODE : s_switch;
    assign sel_match = (CMD_SELECT == eff_code);
    assign CMD_READY = (state_q == SCI_IDLE) && sel_match &&
                       (CMD_WRITE || (buf_cnt_q == 2'h0) || (buf_cnt_q == 2'h1 && !push_q));
    assign accept = CMD_VALID && CMD_READY;
    assign BUSY = busy_q;

    always_comb begin
        is_ctrl = 1'b0;
        for (int i = 0; i < 6; i++) begin
            if (CMD_DATA == CTRL_CHAR[i]) begin
                is_ctrl = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bit clock: divider gives twice the bit rate, toggle halves it
    always_comb begin
        case (s_rate)
            RATE_POS_1200: half_m1 = DIV_W'(HALF_CYC_1200 - 1);
            RATE_POS_600: half_m1 = DIV_W'(HALF_CYC_600 - 1);
            RATE_POS_300: half_m1 = DIV_W'(HALF_CYC_300 - 1);
            RATE_POS_150: half_m1 = DIV_W'(HALF_CYC_150 - 1);
            default: half_m1 = DIV_W'(HALF_CYC_110 - 1);
        endcase
    end

    assign running = (state_q == SCI_TX) || (state_q == SCI_RX_RUN);
    assign tick2x = running && (div_q == half_m1);
    // Transmit shifts on the second tick so the start bit is a whole bit wide;
    // receive shifts on the first so its samples land mid-bit
    assign tx_phase = (state_q == SCI_TX);
    assign shift_edge = tick2x && (tog_q == tx_phase);
    assign last = s_frame11 ? LAST_11BIT : LAST_10BIT;
    assign term = shift_edge && (cnt_q == last);
    // Receive stops shifting after the first stop bit, dropping a second one
    assign shift_en = shift_edge && ((state_q == SCI_TX) ? (cnt_q != last)
                                                          : (cnt_q <= RX_STOP_IDX));

    // Oscillator restarts at the start edge so receive samples land mid-bit
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            div_q <= '0;
            tog_q <= 1'b0;
        end else if (!running) begin
            div_q <= '0;
            tog_q <= 1'b0;
        end else if (tick2x) begin
            div_q <= '0;
            tog_q <= !tog_q;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    // Bit counter
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            cnt_q <= 4'h0;
        end else if (!running || term) begin
            cnt_q <= 4'h0;
        end else if (shift_edge) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode control; reset lands in output mode
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            state_q <= SCI_IDLE;
            busy_q <= 1'b0;
        end else begin
            case (state_q)
                SCI_IDLE: begin
                    if (accept) begin
                        state_q <= CMD_WRITE ? SCI_TX : SCI_RX_ARM;
                        busy_q <= 1'b1;
                    end
                end
                SCI_TX: begin
                    if (term) begin
                        state_q <= SCI_HOLD;
                    end
                end
                SCI_RX_ARM: begin
                    if (!s_din) begin
                        state_q <= SCI_RX_RUN;
                    end
                end
                SCI_RX_RUN: begin
                    if (term) begin
                        state_q <= SCI_IDLE;
                        busy_q <= 1'b0;
                    end
                end
                SCI_HOLD: begin
                    if (s_ext ? !s_pbusy : (dly_q == '0)) begin
                        state_q <= SCI_IDLE;
                        busy_q <= 1'b0;
                    end
                end
                default: begin
                    state_q <= SCI_IDLE;
                    busy_q <= 1'b0;
                end
            endcase
        end
    end

    // One-shot hold-off, started with the request as the original card did
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            dly_q <= '0;
        end else if (accept && CMD_WRITE && is_ctrl && !s_ext) begin
            dly_q <= DIV_W'(DELAY_CYCLES - 1);
        end else if (dly_q != '0) begin
            dly_q <= dly_q - 1'b1;
        end
    end

    // Send-clear is high while waiting and, in alternate mode, up to stop bit
    assign CLEAR_TO_SEND = (state_q == SCI_RX_ARM) ||
                           (state_q == SCI_RX_RUN && s_alt && cnt_q <= RX_STOP_IDX);

    ////////////////////////////////////////////////////////////////////////////
    // Ten-stage shift register, stage 0 toward stage 9
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            sr_q <= 10'h3ff;
        end else if (accept && CMD_WRITE) begin
            sr_q <= {1'b0, rev8(CMD_DATA), 1'b1};
        end else if (shift_en) begin
            sr_q <= {sr_q[8:0], (state_q == SCI_TX) ? 1'b1 : s_din};
        end
    end

    // Line rests at mark outside a transmit frame
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            out_q <= 1'b1;
        end else begin
            out_q <= (state_q == SCI_TX) ? sr_q[9] : 1'b1;
        end
    end

    assign SER_DATA_OUT = out_q;

    ////////////////////////////////////////////////////////////////////////////
    // Two-entry receive buffer; a read is only taken when a slot is free
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            push_q <= 1'b0;
        end else begin
            push_q <= term && (state_q == SCI_RX_RUN);
        end
    end

    always_ff @(posedge MCLK) begin
        if (push_q) begin
            buf_mem[wp_q] <= rev8(sr_q[8:1]);
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            buf_cnt_q <= 2'h0;
        end else begin
            if (push_q) begin
                wp_q <= !wp_q;
            end
            if (RX_VALID && RX_READY) begin
                rp_q <= !rp_q;
            end
            buf_cnt_q <= buf_cnt_q + {1'b0, push_q} - {1'b0, RX_VALID && RX_READY};
        end
    end

    assign RX_VALID = (buf_cnt_q != 2'h0);
    assign RX_DATA = RX_VALID ? buf_mem[rp_q] : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_cts_std;
        @(posedge MCLK) disable iff (!NRST)
        (state_q == SCI_RX_ARM && !s_din && !s_alt) |=> !CLEAR_TO_SEND;
    endproperty
    a_cts_std: assert property (p_cts_std) else $error("send-clear held past start bit");

    property p_cts_alt;
        @(posedge MCLK) disable iff (!NRST)
        (state_q == SCI_RX_RUN && s_alt && cnt_q < RX_STOP_IDX) |-> CLEAR_TO_SEND;
    endproperty
    a_cts_alt: assert property (p_cts_alt) else $error("send-clear dropped early");

    property p_select;
        @(posedge MCLK) disable iff (!NRST)
        CMD_READY |-> (CMD_SELECT == ((s_switch == 4'h0) ? 4'hf : s_switch));
    endproperty
    a_select: assert property (p_select) else $error("answered foreign select code");

    property p_term_len;
        @(posedge MCLK) disable iff (!NRST)
        term |-> (cnt_q == (s_frame11 ? 4'ha : 4'h9));
    endproperty
    a_term_len: assert property (p_term_len) else $error("frame ended at wrong count");

    property p_term_clear;
        @(posedge MCLK) disable iff (!NRST)
        term |=> (cnt_q == 4'h0) && !running;
    endproperty
    a_term_clear: assert property (p_term_clear) else $error("counter not cleared");

    property p_shift;
        @(posedge MCLK) disable iff (!NRST)
        (shift_en && state_q == SCI_TX) |=> (sr_q[9] == $past(sr_q[8])) && sr_q[0];
    endproperty
    a_shift: assert property (p_shift) else $error("shift order broken");

    property p_halve;
        @(posedge MCLK) disable iff (!NRST)
        shift_edge |=> (tog_q != $past(tog_q)) ##1 !shift_edge;
    endproperty
    a_halve: assert property (p_halve) else $error("shift clock not halved");

    property p_ext_hold;
        @(posedge MCLK) disable iff (!NRST)
        (state_q == SCI_HOLD && s_ext && s_pbusy) |=> BUSY && state_q == SCI_HOLD;
    endproperty
    a_ext_hold: assert property (p_ext_hold) else $error("busy released early");

    property p_delay;
        @(posedge MCLK) disable iff (!NRST)
        (accept && CMD_WRITE && is_ctrl && !s_ext) |=> (dly_q == DIV_W'(DELAY_CYCLES - 1));
    endproperty
    a_delay: assert property (p_delay) else $error("hold-off not started");

    property p_out_mode;
        @(posedge MCLK) disable iff (!NRST)
        term |=> (state_q == SCI_IDLE || state_q == SCI_HOLD);
    endproperty
    a_out_mode: assert property (p_out_mode) else $error("not back in output mode");

endmodule

// >>> tb.sv
// Self-checking bench for the serial character interface
`timescale 1ns/100ps
module tb
    import sci_pkg::*;
;
    typedef struct {logic [7:0] data; logic f11; logic [2:0] rate; int half;} sci_row_t;
    // Short hold-off keeps the run brief; longer than any fast frame
    localparam int DLY = 400;
    logic MCLK = 1'b0, NRST = 1'b0, CMD_VALID = 1'b0, CMD_WRITE = 1'b0, RX_READY = 1'b0;
    logic FRAME_LENGTH_STRAP = 1'b0, CTS_HOLDOFF_STRAP = 1'b0, DELAY_SOURCE_STRAP = 1'b0;
    logic PERIPH_BUSY_IN = 1'b0, go = 1'b0, two_stop = 1'b0;
    logic [3:0] CMD_SELECT = 4'hf, SELECT_CODE_SWITCH = 4'h0;
    logic [7:0] CMD_DATA = 8'h00, tx_byte = 8'h00;
    logic [2:0] RATE_SELECTOR = 3'h0;
    wire logic CMD_READY, BUSY, RX_VALID, SER_DATA_OUT, CLEAR_TO_SEND, SER_DATA_IN;
    wire logic [7:0] RX_DATA, got;
    int got_n, n0, len, nb, bit_cyc = 8, bad_count = 0, num_checks = 0, cyc = 0;
    sci_row_t rows [6] = '{'{8'h41, 1'b0, 3'h0, 4}, '{8'h5a, 1'b1, 3'h1, 6},
        '{8'hc3, 1'b0, 3'h2, 8}, '{8'h30, 1'b1, 3'h3, 10}, '{8'h81, 1'b1, 3'h4, 12},
        '{8'h7e, 1'b0, 3'h7, 12}};

    sci_top #(.HALF_CYC_1200(4), .HALF_CYC_600(6), .HALF_CYC_300(8), .HALF_CYC_150(10),
        .HALF_CYC_110(12), .DELAY_CYCLES(DLY)) DUT (.MCLK(MCLK), .NRST(NRST),
        .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY), .CMD_SELECT(CMD_SELECT),
        .CMD_WRITE(CMD_WRITE), .CMD_DATA(CMD_DATA), .BUSY(BUSY), .RX_VALID(RX_VALID),
        .RX_READY(RX_READY), .RX_DATA(RX_DATA), .FRAME_LENGTH_STRAP(FRAME_LENGTH_STRAP),
        .CTS_HOLDOFF_STRAP(CTS_HOLDOFF_STRAP), .DELAY_SOURCE_STRAP(DELAY_SOURCE_STRAP),
        .SELECT_CODE_SWITCH(SELECT_CODE_SWITCH), .RATE_SELECTOR(RATE_SELECTOR),
        .SER_DATA_IN(SER_DATA_IN), .SER_DATA_OUT(SER_DATA_OUT),
        .CLEAR_TO_SEND(CLEAR_TO_SEND), .PERIPH_BUSY_IN(PERIPH_BUSY_IN));
    sci_term_model term (.clk(MCLK), .ser_out(SER_DATA_OUT), .cts(CLEAR_TO_SEND),
        .bit_cyc(bit_cyc), .two_stop(two_stop), .go(go), .tx_byte(tx_byte),
        .ser_in(SER_DATA_IN), .got(got), .got_n(got_n));

    ////////////////////////////////////////////////////////////////
    // Clock and hang guard
    always #10 MCLK = ~MCLK;
    always @(posedge MCLK) begin
        cyc++;
        if (cyc > 30000) begin
            bad_count++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////
    // Comparison and closing report
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("Counts: %0d mismatches, %0d checks", bad_count, num_checks);
        if (bad_count == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Request held until READY seen high at a settled point, dropped on the taking edge
    task automatic req(input logic wr, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge MCLK);
        CMD_VALID <= 1'b1;
        CMD_WRITE <= wr;
        CMD_DATA <= d;
        @(negedge MCLK);
        while (CMD_READY !== 1'b1 && n < 60) begin
            @(negedge MCLK);
            n++;
        end
        chk("cmd_ready", CMD_READY, 1'b1);
        @(posedge MCLK);
        CMD_VALID <= 1'b0;
    endtask
    // Cycles from the call until BUSY is seen low
    task automatic wait_idle();
        len = 0;
        do begin
            @(negedge MCLK);
            len++;
        end while (BUSY !== 1'b0 && len < 3000);
    endtask
    // Read one character sent by the terminal; data is judged when popped
    task automatic rd(input logic f11, input logic holdoff_to_stop_bit, input logic [7:0] b);
        int n;
        @(posedge MCLK);
        FRAME_LENGTH_STRAP <= f11;
        CTS_HOLDOFF_STRAP <= holdoff_to_stop_bit;
        two_stop <= f11;
        tx_byte <= b;
        repeat (4) @(posedge MCLK);
        req(1'b0, 8'h00);
        repeat (2) @(negedge MCLK);
        chk("cts_armed", CLEAR_TO_SEND, 1'b1);
        @(posedge MCLK);
        go <= 1'b1;
        @(posedge MCLK);
        go <= 1'b0;
        n = 0;
        while (SER_DATA_IN !== 1'b0 && n < 50) begin
            @(negedge MCLK);
            n++;
        end
        repeat (bit_cyc) @(negedge MCLK);
        chk("cts_after_start", CLEAR_TO_SEND, holdoff_to_stop_bit);
        wait_idle();
        // Termination falls mid last bit, counted from one bit after the start edge
        chk("rx_len", (len >= (f11 ? 19 : 17) * bit_cyc / 2 &&
            len <= (f11 ? 19 : 17) * bit_cyc / 2 + 8), 1'b1);
        chk("cts_output_mode", CLEAR_TO_SEND, 1'b0);
        repeat (3) @(negedge MCLK);
        chk("rx_valid", RX_VALID, 1'b1);
    endtask
    // Take the oldest buffered character
    task automatic pop(input logic [7:0] exp);
        @(negedge MCLK);
        chk("rx_data", RX_DATA, exp);
        @(posedge MCLK);
        RX_READY <= 1'b1;
        @(posedge MCLK);
        RX_READY <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (2) @(posedge MCLK);
        chk("rst_ser_out", SER_DATA_OUT, 1'b1);
        chk("rst_busy", BUSY, 1'b0);
        chk("rst_cts", CLEAR_TO_SEND, 1'b0);
        chk("rst_rx_valid", RX_VALID, 1'b0);
        chk("rst_rx_data", RX_DATA, 8'h00);
        NRST <= 1'b1;
        repeat (3) @(posedge MCLK);
        // Framing and rate rows; the terminal decodes at the expected rate
        foreach (rows[i]) begin
            FRAME_LENGTH_STRAP <= rows[i].f11;
            RATE_SELECTOR <= rows[i].rate;
            bit_cyc = 2 * rows[i].half;
            nb = 10 + rows[i].f11;
            repeat (4) @(posedge MCLK);
            n0 = got_n;
            req(1'b1, rows[i].data);
            wait_idle();
            chk("frame_len", (len >= nb * bit_cyc - 2 && len <= (nb + 1) * bit_cyc - 2), 1'b1);
            repeat (bit_cyc) @(posedge MCLK);
            chk("term_byte", got, rows[i].data);
            chk("term_count", got_n, n0 + 1);
        end
        // Internal hold-off: every control character, then an ordinary one
        FRAME_LENGTH_STRAP <= 1'b0;
        RATE_SELECTOR <= 3'h0;
        bit_cyc = 8;
        for (int i = 0; i < 7; i++) begin
            req(1'b1, (i < 6) ? CTRL_CHAR[i] : 8'h08);
            wait_idle();
            chk("hold_off", (i < 6) ? (len >= DLY && len <= DLY + 4) : (len < 100), 1'b1);
        end
        // External busy holds BUSY and refuses requests until released
        @(posedge MCLK);
        DELAY_SOURCE_STRAP <= 1'b1;
        PERIPH_BUSY_IN <= 1'b1;
        repeat (4) @(posedge MCLK);
        req(1'b1, 8'h0d);
        repeat (200) @(negedge MCLK);
        chk("ext_hold", BUSY, 1'b1);
        chk("busy_refuse", CMD_READY, 1'b0);
        @(posedge MCLK);
        PERIPH_BUSY_IN <= 1'b0;
        wait_idle();
        chk("ext_release", (len <= 6), 1'b1);
        @(posedge MCLK);
        DELAY_SOURCE_STRAP <= 1'b0;
        // Wrong select code is ignored, matching switch is served
        SELECT_CODE_SWITCH <= 4'h3;
        CMD_SELECT <= 4'h5;
        CMD_VALID <= 1'b1;
        CMD_WRITE <= 1'b1;
        repeat (20) @(negedge MCLK);
        chk("sel_refuse", CMD_READY, 1'b0);
        @(posedge MCLK);
        CMD_VALID <= 1'b0;
        CMD_SELECT <= 4'h3;
        req(1'b1, 8'h55);
        wait_idle();
        repeat (10) @(posedge MCLK);
        chk("sel_byte", got, 8'h55);
        SELECT_CODE_SWITCH <= 4'h0;
        CMD_SELECT <= 4'hf;
        // Reads in both hold-off modes; the buffer fills and refuses a third
        rd(1'b0, 1'b0, 8'h4b);
        pop(8'h4b);
        rd(1'b1, 1'b0, 8'hc3);
        rd(1'b0, 1'b1, 8'h5a);
        @(posedge MCLK);
        CMD_VALID <= 1'b1;
        CMD_WRITE <= 1'b0;
        repeat (20) @(negedge MCLK);
        chk("full_refuse", CMD_READY, 1'b0);
        @(posedge MCLK);
        CMD_VALID <= 1'b0;
        pop(8'hc3);
        pop(8'h5a);
        @(negedge MCLK);
        chk("rx_empty", RX_VALID, 1'b0);
        // Reset in mid-frame returns the line to mark and drops busy
        req(1'b1, 8'h41);
        repeat (30) @(posedge MCLK);
        NRST <= 1'b0;
        repeat (2) @(posedge MCLK);
        chk("mid_rst_busy", BUSY, 1'b0);
        chk("mid_rst_ser_out", SER_DATA_OUT, 1'b1);
        chk("mid_rst_cts", CLEAR_TO_SEND, 1'b0);
        NRST <= 1'b1;
        repeat (3) @(posedge MCLK);
        chk("mid_rst_ready", CMD_READY, 1'b1);
        end_of_test();
    end
endmodule
